//--- core/sdram_command_cke_decoder.sv
// Functional notes
// - Command decoded from CS, ACT, mux pins and CKE at rising edge.
// - ACT high: mux pins are RAS/CAS/WE; ACT low: address A16..A14.
// - Reset is asynchronous active low; held high in normal use.
// - Bank group and bank select target bank, or mode register.
// - Bursts never cut short; fixed or per-command length per mode.
// - A17 ignored as reserved during mode register write.
// - Termination input never affects decode; disabled in self refresh.
// - Self refresh exit handled synchronously to the clock.
// - No refresh performed while in power-down.
// - Transitions use prior state, CKE now, CKE before, command now.
// - CKE falling during burst: precharge or active power-down by banks.
// - Idle needs banks closed, no burst, CKE high, timings met.
// - Unlisted state, CKE and command combinations flagged illegal, except CKE high before the edge in power-down or self refresh.
// - Pins ignored in self refresh and power-down until exit.
//
// Command and clock-enable decoder of a synchronous DRAM.
// Assumes command pins synchronous to clk_sys; controller obeys its timings.
`timescale 1ns/10ps

module sdram_command_cke_decoder
  import cmd_cke_pkg::*;
#(
  parameter int  BANKS      = 4,
  parameter bit  PER_CMD_BL = 1'b1   // Burst length chosen per command
) (
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic       clk_en,
  input  wire ca_bus_t    ca,
  input  wire logic       cke,
  input  wire logic       odt,
  output dec_out_t        dec,
  output cke_state_t      state,
  output logic            refresh_active,
  output logic            odt_enabled,
  output logic            burst_busy
);

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  logic        cke_prev;
  logic [2:0]  burst_cnt;
  logic [BANKS-1:0] bank_open;
  logic        pd_closed;

  wire ras_n = ca.mux[MUX_RAS];
  wire cas_n = ca.mux[MUX_CAS];
  wire we_n  = ca.mux[MUX_WE];
  wire sel   = !ca.cs_n && ca.act_n;
  wire c_act  = !ca.cs_n && !ca.act_n;
  wire c_mrs  = sel && !ras_n && !cas_n && !we_n;
  wire c_ref  = sel && !ras_n && !cas_n &&  we_n;
  wire c_pre  = sel && !ras_n &&  cas_n && !we_n;
  wire c_rfu  = sel && !ras_n &&  cas_n &&  we_n;
  wire c_wr   = sel &&  ras_n && !cas_n && !we_n;
  wire c_rd   = sel &&  ras_n && !cas_n &&  we_n;
  wire c_zq   = sel &&  ras_n &&  cas_n && !we_n;
  wire c_nop  = sel &&  ras_n &&  cas_n &&  we_n;
  wire c_des  = ca.cs_n;
  wire a10    = ca.addr[A10_POS];
  wire a12    = ca.addr[A12_POS];
  wire chop   = PER_CMD_BL ? !a12 : 1'b0;

  wire in_low   = (state == ST_PDOWN) || (state == ST_SREF);
  wire hh       = cke_prev && cke;
  wire fall     = cke_prev && !cke;
  wire rise     = !cke_prev && cke;
  wire banks_idle = (bank_open == '0) && (burst_cnt == '0);
  // Idle is judged on the level before this edge; CKE is low on the entry edge
  wire is_idle    = banks_idle && cke_prev;

  wire do_pde   = !in_low && fall && c_des;
  wire do_sre   = !in_low && fall && c_ref && is_idle;
  wire do_pdx   = (state == ST_PDOWN) && rise && c_des;
  wire do_srx   = (state == ST_SREF) && rise && (c_des || c_nop);
  wire go       = !in_low && hh;
  wire do_rd    = go && c_rd && burst_cnt == '0;
  wire do_wr    = go && c_wr && burst_cnt == '0;

  // Anything not in the tables is never acted on; in power-down or self refresh only a refused CKE rise is reported
  wire bad_low  = in_low && rise && !(do_pdx || do_srx);
  wire bad_fall = !in_low && fall && !(do_pde || do_sre);
  wire bad_hh   = go && (c_rfu || ((c_rd || c_wr) && burst_cnt != '0));
  wire bad_rise = !in_low && rise;
  wire illegal  = bad_low || bad_fall || bad_hh || bad_rise;

  dec_out_t next_dec;
  always_comb begin
    next_dec           = '0;
    next_dec.valid     = go || do_pde || do_sre || do_pdx || do_srx;
    next_dec.read      = do_rd;
    next_dec.write     = do_wr;
    next_dec.autoclose = (do_rd || do_wr) && a10;
    next_dec.chop4     = (do_rd || do_wr) && chop;
    next_dec.mrs       = go && c_mrs;
    next_dec.mr_sel    = {ca.bg[0], ca.ba};
    next_dec.cal_long  = go && c_zq && a10;
    next_dec.cal_short = go && c_zq && !a10;
    next_dec.pd_entry  = do_pde;
    next_dec.pd_exit   = do_pdx;
    next_dec.sr_entry  = do_sre;
    next_dec.sr_exit   = do_srx;
    next_dec.nop       = go && c_nop;
    next_dec.deselect  = go && c_des;
    next_dec.illegal   = illegal;
    next_dec.bg        = ca.bg;
    next_dec.ba        = ca.ba;
  end

  // ----------------------------------------------------------------
  // Bank and burst tracking
  // ----------------------------------------------------------------
  wire [$clog2(BANKS)-1:0] bank_idx = ($clog2(BANKS))'(ca.ba);
  wire [2:0] next_len = chop ? CHOP4_CLKS : BURST8_CLKS;

  logic [BANKS-1:0] next_open;
  always_comb begin
    next_open = bank_open;
    if (go && c_act) next_open[bank_idx] = 1'b1;
    if (go && c_pre) begin
      if (a10) next_open = '0;
      else     next_open[bank_idx] = 1'b0;
    end
    if ((do_rd || do_wr) && a10) next_open[bank_idx] = 1'b0;
  end

  // Power-down flavour: all banks closed after the entry edge
  wire pd_kind = (next_open == '0);

  cke_state_t next_state;
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE, ST_ACTIVE, ST_BURST: begin
        if (do_sre)      next_state = ST_SREF;
        else if (do_pde) next_state = ST_PDOWN;
        else if (burst_cnt > 3'h1 || do_rd || do_wr) next_state = ST_BURST;
        else if (next_open != '0) next_state = ST_ACTIVE;
        else             next_state = ST_IDLE;
      end
      ST_PDOWN: if (do_pdx) next_state = pd_closed ? ST_IDLE : ST_ACTIVE;
      ST_SREF:  if (do_srx) next_state = ST_IDLE;
      default:  next_state = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cke_prev  <= 1'b0;
      state     <= ST_IDLE;
      bank_open <= '0;
      burst_cnt <= '0;
      pd_closed <= 1'b1;
      dec       <= '0;
    end else if (clk_en) begin
      cke_prev  <= cke;
      state     <= next_state;
      bank_open <= next_open;
      if (do_rd || do_wr)        burst_cnt <= next_len;
      else if (burst_cnt != '0)  burst_cnt <= burst_cnt - 3'h1;
      if (do_pde)                pd_closed <= pd_kind;
      dec       <= next_dec;
    end
  end

  // ----------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      refresh_active <= 1'b0;
      odt_enabled    <= 1'b0;
      burst_busy     <= 1'b0;
    end else if (clk_en) begin
      refresh_active <= (next_state == ST_SREF);
      odt_enabled    <= odt && (next_state != ST_SREF);
      burst_busy     <= (next_state == ST_BURST);
    end
  end

endmodule

//--- core/cmd_cke_pkg.sv
// Package for the command and clock-enable decoder.
// Assumes a single 25 MHz clock domain.
package cmd_cke_pkg;

  // Pin group of one command cycle
  typedef struct packed {
    logic       cs_n;
    logic       act_n;
    logic [2:0] mux;     // Row strobe, column strobe, write enable / A16..A14
    logic [1:0] bg;
    logic [1:0] ba;
    logic [13:0] addr;   // A13..A0
    logic       a17;
  } ca_bus_t;

  typedef enum logic [10:0] {
    CMD_NONE   = 11'h001,
    CMD_DES    = 11'h002,
    CMD_NOP    = 11'h004,
    CMD_READ   = 11'h008,
    CMD_WRITE  = 11'h010,
    CMD_MRS    = 11'h020,
    CMD_REF    = 11'h040,
    CMD_PRE    = 11'h080,
    CMD_ACT    = 11'h100,
    CMD_ZQ     = 11'h200,
    CMD_ILLEGAL = 11'h400
  } cmd_t;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'h01,
    ST_ACTIVE = 5'h02,
    ST_BURST  = 5'h04,
    ST_PDOWN  = 5'h08,
    ST_SREF   = 5'h10
  } cke_state_t;

  // Decoded result of one edge
  typedef struct packed {
    logic       valid;
    logic       read;
    logic       write;
    logic       autoclose;
    logic       chop4;
    logic       mrs;
    logic [2:0] mr_sel;
    logic       cal_long;
    logic       cal_short;
    logic       pd_entry;
    logic       pd_exit;
    logic       sr_entry;
    logic       sr_exit;
    logic       nop;
    logic       deselect;
    logic       illegal;
    logic [1:0] bg;
    logic [1:0] ba;
  } dec_out_t;

  // Field positions
  localparam int A10_POS = 10;
  localparam int A12_POS = 12;
  localparam int MUX_RAS = 2;
  localparam int MUX_CAS = 1;
  localparam int MUX_WE  = 0;
  // Burst length in clocks (BL8 = 4 clocks)
  localparam logic [2:0] BURST8_CLKS = 3'h4;
  localparam logic [2:0] CHOP4_CLKS  = 3'h2;
  // Reset values
  localparam logic [3:0] BANKS_OPEN_RST = 4'h0;

endpackage

//--- test/cmd_cke_chk.sv
// Port checker for the command decoder.
// Assumes the decoder top ports; attached by bind.
`timescale 1ns/10ps
module cmd_cke_chk import cmd_cke_pkg::*; (
  input wire logic       clk_sys,
  input wire logic       nrst,
  input wire logic       clk_en,
  input wire ca_bus_t    ca,
  input wire logic       cke,
  input wire logic       odt,
  input wire dec_out_t   dec,
  input wire cke_state_t state,
  input wire logic       refresh_active,
  input wire logic       odt_enabled,
  input wire logic       burst_busy
);
  logic cp;
  wire  sel = clk_en && !ca.cs_n && ca.act_n && cp && cke;
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst) cp <= 1'b0;
    else if (clk_en) cp <= cke;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  property p_rd;
    sel && ca.mux == 3'h5 && !burst_busy |=> dec.read
      && dec.autoclose == $past(ca.addr[A10_POS]) && dec.chop4 == !$past(ca.addr[A12_POS]);
  endproperty
  a_rd: assert property (p_rd) else $error("read decode");
  property p_bl;
    dec.read && !dec.chop4 |-> burst_busy [*3];
  endproperty
  a_bl: assert property (p_bl) else $error("burst cut short");
  property p_zq;
    sel && ca.mux == 3'h6 |=> dec.cal_long == $past(ca.addr[A10_POS]) && dec.cal_short != dec.cal_long;
  endproperty
  a_zq: assert property (p_zq) else $error("calibration decode");
  property p_mrs;
    sel && ca.mux == 3'h0 |=> dec.mrs && dec.mr_sel == {$past(ca.bg[0]), $past(ca.ba)};
  endproperty
  a_mrs: assert property (p_mrs) else $error("mode select");
  property p_pde;
    clk_en && cp && !cke && ca.cs_n && state inside {ST_IDLE, ST_ACTIVE} |=>
      dec.pd_entry && state == ST_PDOWN;
  endproperty
  a_pde: assert property (p_pde) else $error("power-down entry");
  property p_hold;
    clk_en && state == ST_PDOWN && !cke |=> state == ST_PDOWN;
  endproperty
  a_hold: assert property (p_hold) else $error("power-down left");
  property p_sre;
    clk_en && !ca.cs_n && ca.act_n && cp && !cke && ca.mux == 3'h1 && state == ST_IDLE
      |=> state == ST_SREF && refresh_active;
  endproperty
  a_sre: assert property (p_sre) else $error("self refresh entry");
  property p_srx;
    clk_en && state == ST_SREF && !cp && cke && ca.cs_n |=> dec.sr_exit && !refresh_active;
  endproperty
  a_srx: assert property (p_srx) else $error("self refresh exit");
  property p_odt;
    refresh_active |-> !odt_enabled;
  endproperty
  a_odt: assert property (p_odt) else $error("termination in self refresh");
  property p_frz;
    !clk_en |=> $stable(state);
  endproperty
  a_frz: assert property (p_frz) else $error("state moved while frozen");
endmodule
bind sdram_command_cke_decoder cmd_cke_chk u_chk (.clk_sys(clk_sys), .nrst(nrst),
  .clk_en(clk_en), .ca(ca), .cke(cke), .odt(odt), .dec(dec), .state(state),
  .refresh_active(refresh_active), .odt_enabled(odt_enabled), .burst_busy(burst_busy));

//--- test/ctrl_model.sv
// Controller model driving command pins and clock enable.
// Assumes one issue call per cycle, just after a rising edge.
`timescale 1ns/10ps
module ctrl_model import cmd_cke_pkg::*; (
  input  wire logic clk_sys,
  output ca_bus_t   ca,
  output logic      cke
);
  initial begin
    ca = '1;
    cke = 1'b1;
  end
  task automatic issue(input logic c, input logic [2:0] m, input logic [13:0] a,
                       input logic k);
    cke <= k;
    if (c)
      ca <= {1'b1, ~ca[22:0]}; // Floating pins
    else
      ca <= {2'b01, m, a[9:6], a, a[0]}; // No NOP issued
  endtask
  // Bank activate; bank is {bg, ba}
  task automatic activate(input logic [3:0] bank);
    cke <= 1'b1;
    ca  <= {2'b00, 3'h0, bank, 14'h0, 1'b0};
  endtask
endmodule

//--- test/tb_sdram_command_cke_decoder.sv
// Self-checking bench for the command decoder.
// Assumes ctrl_model as controller and the bound checker.
`timescale 1ns/10ps
module tb_sdram_command_cke_decoder import cmd_cke_pkg::*; ();
  logic       clk_sys, nrst, clk_en, odt, cke;
  logic       refresh_active, odt_enabled, burst_busy;
  ca_bus_t    ca;
  dec_out_t   dec;
  cke_state_t state;
  int         n_errors, n_compared;
  ctrl_model ctrl (.clk_sys(clk_sys), .ca(ca), .cke(cke));
  sdram_command_cke_decoder uut (.clk_sys(clk_sys), .nrst(nrst), .clk_en(clk_en),
    .ca(ca), .cke(cke), .odt(odt), .dec(dec), .state(state),
    .refresh_active(refresh_active), .odt_enabled(odt_enabled), .burst_busy(burst_busy));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic chk(input string n, input logic [10:0] e, input logic [10:0] s);
    n_compared++;
    if (e !== s) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic go(input logic c, input logic [2:0] m, input logic [13:0] a, input logic k);
    ctrl.issue(c, m, a, k);
    @(posedge clk_sys);
    #1;
  endtask
  task automatic t_read();
    for (int i = 0; i < 4; i++) begin
      go(0, 3'h5, {1'b0, i[1], 1'b0, i[0], 10'h2c5}, 1);
      chk("read", 1, dec.read);
      chk("autoclose", i[0], dec.autoclose);
      chk("chop4", !i[1], dec.chop4);
      chk("bank", 4'hb, {dec.bg, dec.ba});
      if (i == 3) begin
        go(0, 3'h5, 14'h0000, 1);
        chk("refused", 1, dec.illegal);
      end
      repeat (4) go(1, 3'h0, 14'h0, 1);
    end
    go(0, 3'h4, 14'h0, 1);
    chk("write", 1, dec.write);
    repeat (4) go(1, 3'h0, 14'h0, 1);
    chk("deselect", 1, dec.deselect);
  endtask
  task automatic t_cal_mode();
    for (int i = 0; i < 2; i++) begin
      go(0, 3'h6, {3'h0, i[0], 10'h0}, 1);
      chk("cal long", i[0], dec.cal_long);
      chk("cal short", !i[0], dec.cal_short);
      go(0, 3'h0, 14'h02c4 | 14'(i), 1);
      chk("mode write", 1, dec.mrs);
      chk("mode select", 3'h3, dec.mr_sel);
      go(1, 3'h0, 14'h0, 1);
    end
  endtask
  task automatic t_pdown();
    go(1, 3'h0, 14'h0, 0);
    chk("pd entry", 1, dec.pd_entry);
    chk("pd state", ST_PDOWN, state);
    go(0, 3'h5, 14'h0, 0);
    chk("pd hold", ST_PDOWN, state);
    chk("pd read", 0, dec.read);
    go(1, 3'h0, 14'h0, 1);
    chk("pd exit", 1, dec.pd_exit);
    go(1, 3'h0, 14'h0, 1);
    chk("idle", ST_IDLE, state);
  endtask
  task automatic t_active();
    ctrl.activate(4'h1);
    @(posedge clk_sys);
    #1;
    chk("bank open", ST_ACTIVE, state);
    go(1, 3'h0, 14'h0, 0);
    chk("apd state", ST_PDOWN, state);
    go(1, 3'h0, 14'h0, 0);
    go(1, 3'h0, 14'h0, 1);
    chk("apd exit", ST_ACTIVE, state);
    go(0, 3'h2, 14'h0400, 1);
    chk("precharge all", ST_IDLE, state);
  endtask
  task automatic t_sref();
    odt = 1'b1;
    go(0, 3'h1, 14'h0, 0);
    chk("sr entry", 1, dec.sr_entry);
    chk("sr active", 1, refresh_active);
    go(1, 3'h0, 14'h0, 0);
    chk("odt gate", 0, odt_enabled);
    go(1, 3'h0, 14'h0, 1);
    chk("sr exit", 1, dec.sr_exit);
    odt = 1'b0;
    repeat (2) go(1, 3'h0, 14'h0, 1);
    chk("sr left", 0, refresh_active);
  endtask
  task automatic t_freeze();
    clk_en = 1'b0;
    go(0, 3'h5, 14'h0, 1);
    chk("frozen", ST_IDLE, state);
    clk_en = 1'b1;
    go(1, 3'h0, 14'h0, 1);
  endtask
  task automatic give_verdict();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #100us;
    n_errors++;
    give_verdict();
  end
  initial begin
    {nrst, n_errors, n_compared} = '0;
    clk_en = 1'b1;
    odt = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 nrst = 1'b1;
    chk("reset state", ST_IDLE, state);
    go(1, 3'h0, 14'h0, 1);
    chk("rise after reset", 1, dec.illegal);
    t_read();
    t_cal_mode();
    t_pdown();
    t_active();
    t_sref();
    t_freeze();
    give_verdict();
  end
endmodule
